/* inc/sac_consts.svh */
/*
 constants of the converter control link: config word layout, timing counts
 and the controller register map.
 assumes a 50 MHz hclk on both ends.
*/
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// ==========================================
// widths and config word fields
`define SAC_RES_BITS   12
`define SAC_CFG_BITS   6
// first bit on the wire lands in bit 5
`define SAC_CFG_SD     5
`define SAC_CFG_OS     4
`define SAC_CFG_ADDR_HI 3
`define SAC_CFG_ADDR_LO 2
`define SAC_CFG_POL     1
`define SAC_CFG_SLEEP   0
`define SAC_CFG_RST    6'h00
`define SAC_MSB_MASK   12'h800
`define SAC_SAMPLE_RST 1'b1

// ==========================================
// timing, in ns and in hclk cycles
`define SAC_CLK_NS     20
`define SAC_CONV_NS    1600
`define SAC_CONV_CYC   (`SAC_CONV_NS / `SAC_CLK_NS)
`define SAC_STEP_CYC   (`SAC_CONV_CYC / `SAC_RES_BITS)
`define SAC_STB_NS     40
`define SAC_STB_CYC    (`SAC_STB_NS / `SAC_CLK_NS)
`define SAC_ACQ_NS     240
`define SAC_ACQ_CYC    ((`SAC_ACQ_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_WAIT_CYC   ((`SAC_CONV_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_HOLD_NS    20
`define SAC_HOLD_CYC   ((`SAC_HOLD_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_SCK_HALF   4

// ==========================================
// controller registers (byte offsets) and bits
`define SAC_REG_CFG    4'h0
`define SAC_REG_CTRL   4'h4
`define SAC_REG_STATUS 4'h8
`define SAC_REG_DATA   4'hc
`define SAC_CTRL_GO    0
`define SAC_ST_BUSY    0
`define SAC_ST_DONE    1

`endif

/* inc/sac_pkg.sv */
/*
 types of the converter control link: state encodings and state records.
 assumes sac_consts.svh for the widths.
*/
`include "sac_consts.svh"

package sac_pkg;

   // ==========================================
   // basic types
   typedef logic [`SAC_RES_BITS-1:0] sac_word_t;
   typedef logic [`SAC_CFG_BITS-1:0] sac_cfg_t;

   typedef enum logic [1:0] {
      DS_IDLE = 2'b01,
      DS_CONV = 2'b10
   } sac_dst_t;

   typedef enum logic [4:0] {
      HS_IDLE  = 5'b00001,
      HS_STB   = 5'b00010,
      HS_WAIT  = 5'b00100,
      HS_SHIFT = 5'b01000,
      HS_HOLD  = 5'b10000
   } sac_hst_t;

   // ==========================================
   // state records
   typedef struct packed {
      logic [1:0] stb_s, sck_s, sdi_s;
      logic       stb_q, sck_q;
      sac_dst_t   state;
      logic [3:0] step;
      sac_word_t  mask, sar, out_sr, dac;
      logic [4:0] cfg_sr;
      logic [2:0] rx_cnt;
      sac_cfg_t   cfg, act;
      logic       sdo, sdo_oe, sampling, converting, powered_down;
      logic [2:0] mux_pos, mux_neg;
      logic       mux_neg_com;
   } sac_dev_st_t;

   typedef struct packed {
      logic [1:0]  sdo_s;
      sac_hst_t    state;
      logic [7:0]  cnt, acq;
      logic [3:0]  bitc;
      logic        stb, sck, sdi, pend, done, a_wr, hready, hresp;
      sac_cfg_t    tx_sr, cfg;
      sac_word_t   rx_sr, result;
      logic [3:0]  a_addr;
      logic [31:0] hrdata;
   } sac_host_st_t;

endpackage : sac_pkg

/* inc/sac_if.sv */
/*
 link between converter end and controller end: strobe, serial clock,
 serial in and the enabled serial out.
 assumes the bench joins both ends with one instance.
*/
`timescale 1ns/10ps

interface sac_if;
   logic conversion_start_strobe;
   logic sck;
   logic sdi;
   logic sdo;
   logic sdo_oe;
   logic sdo_seen;

   // undriven serial out reads low
   assign sdo_seen = sdo_oe ? sdo : 1'b0;

   modport dev  (input conversion_start_strobe, sck, sdi, output sdo, sdo_oe);
   modport host (output conversion_start_strobe, sck, sdi, input sdo_seen);
endinterface : sac_if

/* hdl/sac_dev.sv */
/*
 converter end: strobe and serial port logic, self-timed approximation
 sequencer, channel select and sleep control.
 assumes the link pins are asynchronous to hclk and comp_in is a
 comparator result settled within one step period of dac_code.
*/
`timescale 1ns/10ps
`include "sac_consts.svh"

module sac_dev (
   input  logic               hclk,
   input  logic               hresetn,
   sac_if.dev                 link,
   input  logic               comp_in,
   output sac_pkg::sac_word_t dac_code,
   output logic [2:0]         mux_pos,
   output logic [2:0]         mux_neg,
   output logic               mux_neg_com,
   output logic               sampling,
   output logic               converting,
   output logic               powered_down
);
   import sac_pkg::*;

   // ==========================================
   // state
   sac_dev_st_t st_ff;
   sac_dev_st_t nxt_st;

   logic      stb_rise;
   logic      stb_low;
   logic      sck_rise;
   logic      sck_fall;
   sac_word_t got;
   sac_cfg_t  word;

   // ==========================================
   // next state
   always_comb begin
      nxt_st = st_ff;
      got    = st_ff.sar;
      word   = st_ff.cfg;

      // two flops on every pin; edges are seen on the second stage only
      nxt_st.stb_s = {st_ff.stb_s[0], link.conversion_start_strobe};
      nxt_st.sck_s = {st_ff.sck_s[0], link.sck};
      nxt_st.sdi_s = {st_ff.sdi_s[0], link.sdi};
      nxt_st.stb_q = st_ff.stb_s[1];
      nxt_st.sck_q = st_ff.sck_s[1];

      stb_low  = ~st_ff.stb_s[1];
      stb_rise = st_ff.stb_s[1] & ~st_ff.stb_q;
      sck_rise = st_ff.sck_s[1] & ~st_ff.sck_q;
      sck_fall = ~st_ff.sck_s[1] & st_ff.sck_q;

      case (st_ff.state)
         DS_IDLE: begin
            if (stb_rise) begin
               // sample taken here with the settings already held
               nxt_st.state      = DS_CONV;
               nxt_st.act        = st_ff.cfg;
               nxt_st.sampling   = 1'b0;
               nxt_st.converting = 1'b1;
               nxt_st.step       = 4'h0;
               nxt_st.sar        = '0;
               nxt_st.mask       = `SAC_MSB_MASK;
               nxt_st.dac        = `SAC_MSB_MASK;
            end else begin
               if (sck_rise && st_ff.rx_cnt < 3'(`SAC_CFG_BITS)) begin
                  nxt_st.cfg_sr = {st_ff.cfg_sr[3:0], st_ff.sdi_s[1]};
                  nxt_st.rx_cnt = st_ff.rx_cnt + 3'h1;
                  if (st_ff.rx_cnt == 3'(`SAC_CFG_BITS - 1)) begin
                     // first bit sent ends in the top position
                     word            = {st_ff.cfg_sr, st_ff.sdi_s[1]};
                     nxt_st.cfg      = word;
                     nxt_st.sampling = 1'b1;
                     // select pair or channel now so the input settles
                     nxt_st.mux_pos     = {word[`SAC_CFG_ADDR_HI], word[`SAC_CFG_ADDR_LO],
                                           word[`SAC_CFG_OS]};
                     nxt_st.mux_neg     = {word[`SAC_CFG_ADDR_HI], word[`SAC_CFG_ADDR_LO],
                                           ~word[`SAC_CFG_OS]};
                     nxt_st.mux_neg_com = word[`SAC_CFG_SD];
                  end
               end
               if (sck_fall) begin
                  // result leaves while config arrives
                  nxt_st.out_sr = {st_ff.out_sr[`SAC_RES_BITS-2:0], 1'b0};
               end
            end
         end

         DS_CONV: begin
            // a new strobe edge has no branch here: it is ignored
            if (st_ff.step == 4'(`SAC_STEP_CYC - 1)) begin
               nxt_st.step = 4'h0;
               got         = comp_in ? (st_ff.sar | st_ff.mask) : st_ff.sar;
               nxt_st.sar  = got;
               nxt_st.mask = st_ff.mask >> 1;
               nxt_st.dac  = got | (st_ff.mask >> 1);
               if (st_ff.mask[0]) begin
                  nxt_st.state      = DS_IDLE;
                  nxt_st.converting = 1'b0;
                  nxt_st.rx_cnt     = 3'h0;
                  nxt_st.dac        = got;
                  // bipolar flips the msb of the offset code
                  nxt_st.out_sr = st_ff.act[`SAC_CFG_POL] ? got
                                  : got ^ `SAC_MSB_MASK;
               end
            end else begin
               nxt_st.step = st_ff.step + 4'h1;
            end
         end

         default: begin
            nxt_st.state      = DS_IDLE;
            nxt_st.converting = 1'b0;
         end
      endcase

      // msb is on the pin as soon as the result loads
      nxt_st.sdo    = nxt_st.out_sr[`SAC_RES_BITS-1];
      nxt_st.sdo_oe = stb_low;
      // low strobe at the end keeps the converter awake
      nxt_st.powered_down = (nxt_st.state == DS_IDLE) & ~stb_low
                            & st_ff.act[`SAC_CFG_SLEEP];
   end

   // ==========================================
   // registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff          <= '0;
         st_ff.state    <= DS_IDLE;
         st_ff.cfg      <= `SAC_CFG_RST;
         st_ff.act      <= `SAC_CFG_RST;
         st_ff.sampling <= `SAC_SAMPLE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================
   // outputs
   assign link.sdo     = st_ff.sdo;
   assign link.sdo_oe  = st_ff.sdo_oe;
   assign dac_code     = st_ff.dac;
   assign mux_pos      = st_ff.mux_pos;
   assign mux_neg      = st_ff.mux_neg;
   assign mux_neg_com  = st_ff.mux_neg_com;
   assign sampling     = st_ff.sampling;
   assign converting   = st_ff.converting;
   assign powered_down = st_ff.powered_down;

endmodule : sac_dev

/* hdl/sac_host.sv */
/*
 controller end: AHB-Lite register slave that runs one conversion and
 serial read per software start.
 assumes one AHB-Lite master, word transfers, and sdo_seen asynchronous.
*/
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
`include "sac_consts.svh"

module sac_host #(
   parameter int SCK_HALF = `SAC_SCK_HALF
) (
   input  logic        hclk,
   input  logic        hresetn,
   sac_if.host         link,
   input  logic        hsel,
   input  logic [31:0] haddr,
   input  logic [1:0]  htrans,
   input  logic        hwrite,
   input  logic [2:0]  hsize,
   input  logic [31:0] hwdata,
   output logic        hreadyout,
   output logic [31:0] hrdata,
   output logic        hresp
);
   import sac_pkg::*;

   // ==========================================
   // state
   sac_host_st_t st_ff;
   sac_host_st_t nxt_st;
   logic         req;
   logic         set_done;

   // ==========================================
   // next state
   always_comb begin
      nxt_st   = st_ff;
      set_done = 1'b0;
      nxt_st.sdo_s  = {st_ff.sdo_s[0], link.sdo_seen};
      nxt_st.hready = 1'b1;
      nxt_st.hresp  = 1'b0;
      nxt_st.cnt    = st_ff.cnt + 8'h1;
      if (st_ff.acq != 8'hff)
         nxt_st.acq = st_ff.acq + 8'h1;

      case (st_ff.state)
         HS_IDLE: begin
            nxt_st.cnt = 8'h0;
            if (st_ff.pend && st_ff.acq >= 8'(`SAC_ACQ_CYC)) begin
               nxt_st.pend  = 1'b0;
               nxt_st.stb   = 1'b1;
               nxt_st.tx_sr = st_ff.cfg;
               nxt_st.state = HS_STB;
            end
         end
         HS_STB: begin
            if (st_ff.cnt == 8'(`SAC_STB_CYC - 1)) begin
               nxt_st.stb   = 1'b0;
               nxt_st.cnt   = 8'h0;
               nxt_st.state = HS_WAIT;
            end
         end
         HS_WAIT: begin
            if (st_ff.cnt == 8'(`SAC_WAIT_CYC - 1)) begin
               nxt_st.cnt   = 8'h0;
               nxt_st.bitc  = 4'h0;
               nxt_st.sdi   = st_ff.tx_sr[`SAC_CFG_BITS-1];
               nxt_st.state = HS_SHIFT;
            end
         end
         HS_SHIFT: begin
            if (st_ff.cnt == 8'(SCK_HALF - 1)) begin
               nxt_st.sck = 1'b1;
               if (st_ff.bitc == 4'(`SAC_CFG_BITS - 1))
                  nxt_st.acq = 8'h0;
            end
            // sample late in the high half, after the device shifted
            if (st_ff.cnt == 8'(2 * SCK_HALF - 2))
               nxt_st.rx_sr = {st_ff.rx_sr[`SAC_RES_BITS-2:0], st_ff.sdo_s[1]};
            if (st_ff.cnt == 8'(2 * SCK_HALF - 1)) begin
               nxt_st.sck   = 1'b0;
               nxt_st.cnt   = 8'h0;
               nxt_st.tx_sr = {st_ff.tx_sr[`SAC_CFG_BITS-2:0], 1'b0};
               nxt_st.sdi   = st_ff.tx_sr[`SAC_CFG_BITS-2];
               nxt_st.bitc  = st_ff.bitc + 4'h1;
               if (st_ff.bitc == 4'(`SAC_RES_BITS - 1))
                  nxt_st.state = HS_HOLD;
            end
         end
         HS_HOLD: begin
            // strobe stays low past the last falling edge
            if (st_ff.cnt == 8'(`SAC_HOLD_CYC - 1)) begin
               nxt_st.result = st_ff.rx_sr;
               nxt_st.sdi    = 1'b0;
               set_done      = 1'b1;
               nxt_st.state  = HS_IDLE;
            end
         end
         default: begin
            nxt_st.state = HS_IDLE;
            nxt_st.stb   = 1'b0;
            nxt_st.sck   = 1'b0;
         end
      endcase

      // ==========================================
      // bus slave: read data is prepared in the address phase
      req = hsel & hready_in() & htrans[1] & (hsize == 3'b010) & (haddr[31:4] == 28'h0);
      nxt_st.a_wr   = req & hwrite;
      nxt_st.a_addr = haddr[3:0];
      nxt_st.hrdata = 32'h0;
      if (req && !hwrite) begin
         case (haddr[3:0])
            `SAC_REG_CFG:    nxt_st.hrdata = {26'h0, st_ff.cfg};
            `SAC_REG_STATUS: nxt_st.hrdata = {30'h0, st_ff.done,
                                             (st_ff.state != HS_IDLE) | st_ff.pend};
            `SAC_REG_DATA:   nxt_st.hrdata = {20'h0, st_ff.result};
            default:         nxt_st.hrdata = 32'h0;
         endcase
      end
      if (st_ff.a_wr) begin
         case (st_ff.a_addr)
            `SAC_REG_CFG:    nxt_st.cfg  = hwdata[`SAC_CFG_BITS-1:0];
            `SAC_REG_CTRL:   nxt_st.pend = nxt_st.pend | hwdata[`SAC_CTRL_GO];
            `SAC_REG_STATUS: nxt_st.done = st_ff.done & ~hwdata[`SAC_ST_DONE];
            default:         nxt_st.pend = nxt_st.pend;
         endcase
      end
      // a finishing transfer beats a clear in the same cycle
      if (set_done)
         nxt_st.done = 1'b1;
   end

   // the only slave: its own ready is the bus ready
   function automatic logic hready_in();
      hready_in = st_ff.hready;
   endfunction : hready_in

   // ==========================================
   // registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff       <= '0;
         st_ff.state <= HS_IDLE;
         st_ff.cfg   <= `SAC_CFG_RST;
         st_ff.acq   <= 8'hff;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================
   // outputs
   assign link.conversion_start_strobe = st_ff.stb;
   assign link.sck                     = st_ff.sck;
   assign link.sdi                     = st_ff.sdi;
   assign hreadyout                    = st_ff.hready;
   assign hrdata                       = st_ff.hrdata;
   assign hresp                        = st_ff.hresp;

endmodule : sac_host

/* verif/sac_sva.sv */
/*
 checker of the link between converter end and controller end.
 assumes one hclk domain and the bench wires it beside the link.
*/
`timescale 1ns/10ps
`include "sac_consts.svh"

module sac_sva (
   input logic               hclk,
   input logic               hresetn,
   input logic               conversion_start_strobe,
   input logic               sck,
   input logic               sdi,
   input logic               sdo,
   input logic               sdo_oe,
   input sac_pkg::sac_word_t dac_code,
   input logic [2:0]         mux_pos,
   input logic [2:0]         mux_neg,
   input logic               mux_neg_com,
   input logic               sampling,
   input logic               converting,
   input logic               powered_down
);
   import sac_pkg::*;

   // ==========================================
   // helpers: sck rises since strobe, config bits as sent
   logic [2:0] rise_ff;
   logic [5:0] cap_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rise_ff <= 3'h0;
         cap_ff  <= 6'h00;
      end else if (conversion_start_strobe) begin
         rise_ff <= 3'h0;
      end else if ($rose(sck) && rise_ff != 3'h7) begin
         rise_ff <= rise_ff + 3'h1;
         if (rise_ff < 3'h6) begin
            cap_ff <= {cap_ff[4:0], sdi};
         end
      end
   end

   // ==========================================
   // properties
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // sync lag of the device allows a few cycles
   sequence conv_run_s;
      ##60 converting ##[1:20] !converting;
   endsequence
   sequence oe_drop_s;
      ##[1:4] !sdo_oe;
   endsequence
   // strobe drops before the first decision, then stays low through acquisition
   sequence stb_drop_s;
      ##2 !conversion_start_strobe;
   endsequence
   sequence acq_gap_s;
      (!conversion_start_strobe) [*8] ##1 (!conversion_start_strobe) [*4];
   endsequence

   strb_start_a: assert property ($rose(conversion_start_strobe) && !converting
      |-> ##[1:4] $rose(converting)) else $error("no start after strobe");
   conv_time_a: assert property ($rose(converting) |-> conv_run_s)
      else $error("conversion length wrong");
   msb_first_a: assert property ($rose(converting)
      |-> ##[0:7] dac_code == `SAC_MSB_MASK) else $error("first trial not msb");
   oe_off_a: assert property ($rose(conversion_start_strobe) |-> oe_drop_s)
      else $error("sdo still driven with strobe high");
   oe_on_a: assert property ($rose(sdo_oe) |-> !conversion_start_strobe)
      else $error("sdo enabled with strobe high");
   sdo_hold_a: assert property ($rose(sck) |-> ##2 $stable(sdo) [*3])
      else $error("sdo moved outside sck fall");
   acq_start_a: assert property ($rose(sck) && rise_ff == 3'h5
      |-> ##[1:4] $rose(sampling)) else $error("no acquisition after 6th bit");
   acq_only_a: assert property ($rose(sampling) |-> rise_ff == 3'h6)
      else $error("acquisition at wrong bit");
   cfg_mux_a: assert property ($rose(sck) && rise_ff == 3'h5
      |-> ##[2:5] (mux_pos == {cap_ff[3:2], cap_ff[4]} && mux_neg_com == cap_ff[5]
      && (cap_ff[5] || mux_neg == {cap_ff[3:2], ~cap_ff[4]})))
      else $error("mux does not follow config");
   // bipolar output flips the msb of the raw code; polarity bit as last sent
   sdo_msb_a: assert property ($fell(converting) && sdo_oe
      |-> ##[0:3] sdo == (dac_code[11] ^ ~cap_ff[1])) else $error("msb not shown at end");
   sleep_idle_a: assert property (powered_down |-> !converting)
      else $error("asleep while converting");
   stb_short_a: assert property ($rose(conversion_start_strobe) |-> stb_drop_s)
      else $error("strobe held high too long");
   acq_time_a: assert property ($rose(sck) && rise_ff == 3'h5 |-> acq_gap_s)
      else $error("start before acquisition time");

endmodule : sac_sva

/* verif/tb.sv */
/*
 bench: both ends joined by sac_if, an AHB-Lite master and a comparator.
 assumes the register map and widths of sac_consts.svh.
*/
`timescale 1ns/10ps
`include "sac_consts.svh"

module tb;
   import sac_pkg::*;

   typedef struct {logic [5:0] cfg; logic [2:0] pos; logic [2:0] neg; logic com;} sac_row_t;

   // ==========================================
   // signals and tables
   logic        hclk, hresetn, hsel, hwrite, comp_in;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize, mux_pos, mux_neg;
   logic        hreadyout, hresp, mux_neg_com, sampling, converting, powered_down;
   sac_word_t   dac_code;
   int          err_count, cmp_count, n_stb, base;
   logic [5:0]  prev_cfg;
   sac_word_t   chan_v [8] = '{12'h000, 12'h123, 12'h456, 12'h789,
                               12'habc, 12'hdef, 12'hfff, 12'h801};
   sac_row_t    rows [8] = '{'{6'h02, 3'h0, 3'h1, 1'b0},
                             '{6'h14, 3'h3, 3'h2, 1'b0},
                             '{6'h0a, 3'h4, 3'h5, 1'b0},
                             '{6'h1c, 3'h7, 3'h6, 1'b0},
                             '{6'h26, 3'h2, 3'h0, 1'b1},
                             '{6'h30, 3'h1, 3'h0, 1'b1},
                             '{6'h3a, 3'h5, 3'h0, 1'b1},
                             '{6'h2d, 3'h6, 3'h0, 1'b1}};

   sac_if sac_if_inst ();
   sac_dev sac_dev_inst (.hclk(hclk), .hresetn(hresetn), .link(sac_if_inst),
      .comp_in(comp_in), .dac_code(dac_code), .mux_pos(mux_pos), .mux_neg(mux_neg),
      .mux_neg_com(mux_neg_com), .sampling(sampling), .converting(converting),
      .powered_down(powered_down));
   sac_host #(.SCK_HALF(4)) sac_host_inst (.hclk(hclk), .hresetn(hresetn),
      .link(sac_if_inst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
   sac_sva sac_sva_inst (.hclk(hclk), .hresetn(hresetn),
      .conversion_start_strobe(sac_if_inst.conversion_start_strobe), .sck(sac_if_inst.sck),
      .sdi(sac_if_inst.sdi), .sdo(sac_if_inst.sdo), .sdo_oe(sac_if_inst.sdo_oe),
      .dac_code(dac_code), .mux_pos(mux_pos), .mux_neg(mux_neg), .mux_neg_com(mux_neg_com),
      .sampling(sampling), .converting(converting), .powered_down(powered_down));

   // ==========================================
   // clock, comparator of the selected channel, strobe count
   initial hclk = 1'b0;
   always #10 hclk = ~hclk;
   always @(posedge hclk) comp_in <= (chan_v[mux_pos] >= dac_code);
   always @(posedge sac_if_inst.conversion_start_strobe) n_stb++;

   // ==========================================
   // tasks
   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // whole-word single transfer; rd holds read data
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      hsize  <= 3'b010;
      // no wait count assumed: only the watchdog ends a stuck transfer
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer

   task wait_done(input int n);
      for (int k = 0; k < 300; k++) begin
         xfer(1'b0, `SAC_REG_STATUS, 32'h0);
         if (n_stb >= n && rd[`SAC_ST_BUSY] === 1'b0 && rd[`SAC_ST_DONE] === 1'b1) return;
      end
      // a missing strobe must fail even when done is left over
      check(rd | {31'h0, (n_stb < n)}, 32'h2, "no completion");
   endtask : wait_done

   // previous config picks channel 2*addr+odd and the output code
   function automatic sac_word_t exp_res(input logic [5:0] c);
      sac_word_t v;
      v = chan_v[{c[3:2], c[4]}];
      return c[1] ? v : v ^ `SAC_MSB_MASK;
   endfunction : exp_res

   task report_and_stop();
      $display("errors %0d comparisons %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   // ==========================================
   // sequence
   initial begin
      {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
      prev_cfg = 6'h00;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (rows[i]) begin
         base = n_stb;
         xfer(1'b1, `SAC_REG_CFG, {26'h0, rows[i].cfg});
         xfer(1'b1, `SAC_REG_CTRL, 32'h1);
         wait_done(base + 1);
         xfer(1'b0, `SAC_REG_DATA, 32'h0);
         check(rd, {20'h0, exp_res(prev_cfg)}, "result");
         check({29'h0, mux_pos}, {29'h0, rows[i].pos}, "positive input");
         check({31'h0, mux_neg_com}, {31'h0, rows[i].com}, "common return");
         if (!rows[i].com) check({29'h0, mux_neg}, {29'h0, rows[i].neg}, "pair");
         xfer(1'b1, `SAC_REG_STATUS, 32'h2);
         xfer(1'b0, `SAC_REG_STATUS, 32'h0);
         check(rd, 32'h0, "done cleared");
         prev_cfg = rows[i].cfg;
      end
      // second start while busy is queued: two conversions, same config
      base = n_stb;
      xfer(1'b1, `SAC_REG_CTRL, 32'h1);
      xfer(1'b1, `SAC_REG_CTRL, 32'h1);
      wait_done(base + 2);
      check(n_stb - base, 2, "starts");
      xfer(1'b0, `SAC_REG_DATA, 32'h0);
      check(rd, {20'h0, exp_res(prev_cfg)}, "queued result");
      // sleep bit set, but the strobe stayed low at the end
      check({31'h0, powered_down}, 32'h0, "awake with strobe low");
      // field width, write-only and unmapped places
      xfer(1'b1, `SAC_REG_CFG, 32'hffffffff);
      xfer(1'b0, `SAC_REG_CFG, 32'h0);
      check(rd, 32'h3f, "config width");
      xfer(1'b0, `SAC_REG_CTRL, 32'h0);
      check(rd, 32'h0, "control reads zero");
      xfer(1'b1, 32'h10, 32'h5a);
      xfer(1'b0, 32'h10, 32'h0);
      check(rd, 32'h0, "unmapped");
      check({31'h0, hresp}, 32'h0, "response");
      // reset in mid conversion, then a fresh run on reset config
      xfer(1'b1, `SAC_REG_CTRL, 32'h1);
      repeat (40) @(posedge hclk);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(1'b0, `SAC_REG_CFG, 32'h0);
      check(rd, 32'h0, "config after reset");
      xfer(1'b0, `SAC_REG_STATUS, 32'h0);
      check(rd, 32'h0, "status after reset");
      xfer(1'b0, `SAC_REG_DATA, 32'h0);
      check(rd, 32'h0, "data after reset");
      base = n_stb;
      xfer(1'b1, `SAC_REG_CTRL, 32'h1);
      wait_done(base + 1);
      xfer(1'b0, `SAC_REG_DATA, 32'h0);
      check(rd, {20'h0, exp_res(6'h00)}, "result after reset");
      report_and_stop();
   end

   // runs take some 2.2k cycles; the 20k-cycle limit means a hang
   initial begin
      #400000;
      err_count++;
      report_and_stop();
   end

endmodule : tb
